// *** iod_pkg.sv ***
package iod_pkg;

  // ----------------------------------------------------------------
  // I/O port addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] IOD_DMA1_LO     = 16'h0000;
  localparam logic [15:0] IOD_DMA1_HI     = 16'h000F;
  localparam logic [15:0] IOD_PIC1_LO     = 16'h0020;
  localparam logic [15:0] IOD_PIC1_HI     = 16'h0021;
  localparam logic [15:0] IOD_CFG_IDX     = 16'h0022;
  localparam logic [15:0] IOD_CFG_DAT     = 16'h0023;
  localparam logic [15:0] IOD_SMM_IDX     = 16'h0026;
  localparam logic [15:0] IOD_SMM_DAT     = 16'h0027;
  localparam logic [15:0] IOD_PIT_LO      = 16'h0040;
  localparam logic [15:0] IOD_PIT_HI      = 16'h0043;
  localparam logic [15:0] IOD_KBD_CLR     = 16'h0060;
  localparam logic [15:0] IOD_SYS_CTL     = 16'h0061;

  // ----------------------------------------------------------------
  // System control port fields
  // ----------------------------------------------------------------
  localparam int          IOD_SC_GATE     = 0;
  localparam int          IOD_SC_SPKR     = 1;
  localparam int          IOD_SC_PAR_DIS  = 2;
  localparam int          IOD_SC_CHK_DIS  = 3;
  localparam int          IOD_SC_REFRESH  = 4;
  localparam int          IOD_SC_T2OUT    = 5;
  localparam logic [3:0]  IOD_SC_WR_RST   = 4'h0;
  localparam logic [7:0]  IOD_SC_DEFAULT  = 8'h20;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          IOD_CLK_MHZ     = 40;
  localparam int          IOD_REFRESH_NS  = 15000;
  localparam int          IOD_REFRESH_CYC = IOD_REFRESH_NS * IOD_CLK_MHZ / 1000;

  typedef enum logic [1:0] {
    IOD_WIN_IDLE,
    IOD_WIN_ARMED,
    IOD_WIN_USED
  } iod_win_t;

endpackage : iod_pkg

// *** iod_refresh.sv ***
`timescale 1ns/1ps
module iod_refresh
  import iod_pkg::*;
#(
  parameter int PERIOD = IOD_REFRESH_CYC
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  output logic      refresh_tick,
  output logic      refresh_toggle
);

  logic [$clog2(PERIOD)-1:0] cnt_reg;

  // ----------------------------------------------------------------
  // Refresh period divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (cnt_reg == ($clog2(PERIOD))'(PERIOD - 1)) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign refresh_tick = (cnt_reg == ($clog2(PERIOD))'(PERIOD - 1));

  // Free running: keeps toggling whether or not bus refresh is enabled
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refresh_toggle <= 1'b0;
    end else if (refresh_tick) begin
      refresh_toggle <= ~refresh_toggle;
    end
  end

endmodule : iod_refresh

// *** iod_check_ff.sv ***
`timescale 1ns/1ps
module iod_check_ff (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic par_dis,
  input  wire logic par_err,
  input  wire logic par_block,
  input  wire logic chk_dis,
  input  wire logic iochck_n,
  output logic      parity_check_n,
  output logic      chan_check_q,
  output logic      chan_check_nmi_n
);

  logic par_q_reg;
  logic chk_q_reg;

  // ----------------------------------------------------------------
  // Parity error flip-flop
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      par_q_reg <= 1'b1;
    end else if (par_dis) begin
      par_q_reg <= 1'b1;
    end else if (par_err && !par_block) begin
      par_q_reg <= 1'b0;
    end
  end

  // Preset acts as a level, so it overrides the stored state at once
  assign parity_check_n = par_q_reg | par_dis;

  // ----------------------------------------------------------------
  // Channel check flip-flop
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chk_q_reg <= 1'b0;
    end else if (!iochck_n) begin
      chk_q_reg <= 1'b1;
    end else if (chk_dis) begin
      chk_q_reg <= 1'b0;
    end
  end

  // Preset wins on the true output, clear wins on the inverted one
  assign chan_check_q     = ~iochck_n | (chk_q_reg & ~chk_dis);
  assign chan_check_nmi_n = chk_dis | ~(~iochck_n | chk_q_reg);

endmodule : iod_check_ff

// *** iod_port_decode.sv ***
`timescale 1ns/1ps
// Function
// - DMA 1 decoded at 00-0F only
// - Interrupt controller 1 at 20-21 only
// - Port 22 latches configuration index, write only
// - Second 23 access ignored until 22 rewritten
// - Port 26 separate write-only system management index
// - Port 27 uses 26 index, own flag
// - Timer decoded at 40-43 only
// - Reading 60 clears keyboard and mouse latches
// - Port 61 bits 0-3 RW, 6-7 read zero
// - Port 61 reads 20h after reset
// - Bit 0 gates timer 2 clock
// - Gate low forces timer 2 status one
// - Speaker is NAND of data and timer output
// - Bit 2 disables parity, presets flip-flop
// - Parity error clears flip-flop, preset dominates
// - Index bit blocks parity flip-flop clocking
// - Bit 3 disables channel check, clears flip-flop
// - IOCHCK# presets channel check flip-flop
// - Bit 4 toggles on each refresh
module iod_port_decode
  import iod_pkg::*;
#(
  parameter int ADDR_W      = 16,
  parameter int REFRESH_CYC = IOD_REFRESH_CYC
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] io_addr,
  input  wire logic              io_rd,
  input  wire logic              io_wr,
  input  wire logic [7:0]        io_wdata,
  output logic      [7:0]        io_rdata,
  output logic                   io_rdata_valid,
  output logic                   dma1_sel,
  output logic                   pic1_sel,
  output logic                   pit_sel,
  output logic      [7:0]        cfg_index,
  output logic                   cfg_smm,
  output logic                   cfg_rd,
  output logic                   cfg_wr,
  output logic      [7:0]        cfg_wdata,
  input  wire logic [7:0]        cfg_rdata,
  input  wire logic              kbd_irq_set,
  input  wire logic              mouse_irq_set,
  output logic                   irq1,
  output logic                   irq12,
  input  wire logic              timer_clk_tick,
  input  wire logic              tmr2_out,
  output logic                   tmr2_gate,
  output logic                   tmr2_clk_en,
  output logic                   speaker,
  input  wire logic              par_err,
  input  wire logic              par_block,
  input  wire logic              iochck_n,
  output logic                   parity_check_n,
  output logic                   chan_check_q,
  output logic                   chan_check_nmi_n,
  output logic                   refresh_tick
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [15:0] addr16;
  logic        hit_cfg_idx;
  logic        hit_cfg_dat;
  logic        hit_smm_idx;
  logic        hit_smm_dat;
  logic        hit_kbd;
  logic        hit_sysctl;

  assign addr16 = 16'(io_addr);

  // Full compares keep the legacy alias ranges dead
  assign dma1_sel = (io_rd | io_wr)
                    && (addr16 >= IOD_DMA1_LO)
                    && (addr16 <= IOD_DMA1_HI);
  assign pic1_sel = (io_rd | io_wr)
                    && (addr16 >= IOD_PIC1_LO)
                    && (addr16 <= IOD_PIC1_HI);
  assign pit_sel  = (io_rd | io_wr)
                    && (addr16 >= IOD_PIT_LO)
                    && (addr16 <= IOD_PIT_HI);

  assign hit_cfg_idx = (addr16 == IOD_CFG_IDX);
  assign hit_cfg_dat = (addr16 == IOD_CFG_DAT);
  assign hit_smm_idx = (addr16 == IOD_SMM_IDX);
  assign hit_smm_dat = (addr16 == IOD_SMM_DAT);
  assign hit_kbd     = (addr16 == IOD_KBD_CLR);
  assign hit_sysctl  = (addr16 == IOD_SYS_CTL);

  // ----------------------------------------------------------------
  // Configuration index windows
  // ----------------------------------------------------------------
  logic [7:0] cfg_idx_reg;
  logic [7:0] smm_idx_reg;
  iod_win_t   cfg_win_reg;
  iod_win_t   smm_win_reg;
  logic       cfg_dat_ok;
  logic       smm_dat_ok;

  // Index ports are write only; a read of them is not claimed
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_idx_reg <= 8'h00;
    end else if (io_wr && hit_cfg_idx) begin
      cfg_idx_reg <= io_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      smm_idx_reg <= 8'h00;
    end else if (io_wr && hit_smm_idx) begin
      smm_idx_reg <= io_wdata;
    end
  end

  assign cfg_dat_ok = (cfg_win_reg == IOD_WIN_ARMED);
  assign smm_dat_ok = (smm_win_reg == IOD_WIN_ARMED);

  // Software is expected to rewrite the index each time; a stale
  // data access is dropped rather than reaching the old register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_win_reg <= IOD_WIN_IDLE;
    end else begin
      case (cfg_win_reg)
        IOD_WIN_IDLE,
        IOD_WIN_USED: begin
          if (io_wr && hit_cfg_idx) begin
            cfg_win_reg <= IOD_WIN_ARMED;
          end
        end
        IOD_WIN_ARMED: begin
          if (io_wr && hit_cfg_idx) begin
            cfg_win_reg <= IOD_WIN_ARMED;
          end else if ((io_rd || io_wr) && hit_cfg_dat) begin
            cfg_win_reg <= IOD_WIN_USED;
          end
        end
        default: begin
          cfg_win_reg <= IOD_WIN_IDLE;
        end
      endcase
    end
  end

  // Separate flag so the management window never disturbs the normal one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      smm_win_reg <= IOD_WIN_IDLE;
    end else begin
      case (smm_win_reg)
        IOD_WIN_IDLE,
        IOD_WIN_USED: begin
          if (io_wr && hit_smm_idx) begin
            smm_win_reg <= IOD_WIN_ARMED;
          end
        end
        IOD_WIN_ARMED: begin
          if (io_wr && hit_smm_idx) begin
            smm_win_reg <= IOD_WIN_ARMED;
          end else if ((io_rd || io_wr) && hit_smm_dat) begin
            smm_win_reg <= IOD_WIN_USED;
          end
        end
        default: begin
          smm_win_reg <= IOD_WIN_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration register strobes
  // ----------------------------------------------------------------
  logic cfg_go;
  logic smm_go;

  assign cfg_go = hit_cfg_dat && cfg_dat_ok;
  assign smm_go = hit_smm_dat && smm_dat_ok;

  assign cfg_rd    = io_rd && (cfg_go || smm_go);
  assign cfg_wr    = io_wr && (cfg_go || smm_go);
  assign cfg_smm   = smm_go;
  assign cfg_index = smm_go ? smm_idx_reg : cfg_idx_reg;
  assign cfg_wdata = io_wdata;

  // ----------------------------------------------------------------
  // Keyboard and mouse interrupt latches
  // ----------------------------------------------------------------
  logic kbd_clr;

  assign kbd_clr = io_rd && hit_kbd;

  // A new request in the clearing cycle survives the clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq1 <= 1'b0;
    end else if (kbd_irq_set) begin
      irq1 <= 1'b1;
    end else if (kbd_clr) begin
      irq1 <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq12 <= 1'b0;
    end else if (mouse_irq_set) begin
      irq12 <= 1'b1;
    end else if (kbd_clr) begin
      irq12 <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // System control port
  // ----------------------------------------------------------------
  logic [3:0] sc_wr_reg;
  logic       t2_status;
  logic       refresh_bit;
  logic [7:0] sc_read;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sc_wr_reg <= IOD_SC_WR_RST;
    end else if (io_wr && hit_sysctl) begin
      sc_wr_reg <= io_wdata[3:0];
    end
  end

  assign tmr2_gate   = sc_wr_reg[IOD_SC_GATE];
  assign tmr2_clk_en = tmr2_gate && timer_clk_tick;

  // Stopped timer reads as high so the speaker is the inverse of the data bit
  assign t2_status = tmr2_out | ~tmr2_gate;

  assign speaker = ~(sc_wr_reg[IOD_SC_SPKR] & t2_status);

  // Latch bits 6 and 7 live outside; this port reads them as zero
  always_comb begin
    sc_read                 = 8'h00;
    sc_read[3:0]            = sc_wr_reg;
    sc_read[IOD_SC_REFRESH] = refresh_bit;
    sc_read[IOD_SC_T2OUT]   = t2_status;
  end

  iod_refresh #(
    .PERIOD (REFRESH_CYC)
  ) u_refresh (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .refresh_tick   (refresh_tick),
    .refresh_toggle (refresh_bit)
  );

  iod_check_ff u_check (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .par_dis          (sc_wr_reg[IOD_SC_PAR_DIS]),
    .par_err          (par_err),
    .par_block        (par_block),
    .chk_dis          (sc_wr_reg[IOD_SC_CHK_DIS]),
    .iochck_n         (iochck_n),
    .parity_check_n   (parity_check_n),
    .chan_check_q     (chan_check_q),
    .chan_check_nmi_n (chan_check_nmi_n)
  );

  // ----------------------------------------------------------------
  // Read data return
  // ----------------------------------------------------------------
  // Data is registered: the answer comes one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_rdata <= 8'h00;
    end else if (io_rd && (cfg_go || smm_go)) begin
      io_rdata <= cfg_rdata;
    end else if (io_rd && hit_sysctl) begin
      io_rdata <= sc_read;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_rdata_valid <= 1'b0;
    end else begin
      io_rdata_valid <= io_rd && (cfg_go || smm_go || hit_sysctl);
    end
  end

endmodule : iod_port_decode

// *** iod_port_decode_sva.sv ***
`timescale 1ns/1ps
module iod_port_decode_sva
  import iod_pkg::*;
#(
  parameter int ADDR_W      = 16,
  parameter int REFRESH_CYC = IOD_REFRESH_CYC
) (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] io_addr,
  input wire logic              io_rd,
  input wire logic              io_wr,
  input wire logic [7:0]        io_wdata,
  input wire logic [7:0]        io_rdata,
  input wire logic              io_rdata_valid,
  input wire logic              dma1_sel,
  input wire logic              pic1_sel,
  input wire logic              pit_sel,
  input wire logic [7:0]        cfg_index,
  input wire logic              cfg_smm,
  input wire logic              cfg_rd,
  input wire logic              cfg_wr,
  input wire logic              kbd_irq_set,
  input wire logic              irq1,
  input wire logic              timer_clk_tick,
  input wire logic              tmr2_gate,
  input wire logic              tmr2_clk_en,
  input wire logic              parity_check_n,
  input wire logic              refresh_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic strb;
  logic used23;
  logic seen;
  int   cnt;
  assign strb = io_rd || io_wr;
  // -------------------------------------------------------------
  // Helper state
  // -------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst || (io_wr && io_addr == IOD_CFG_IDX)) used23 <= 1'h0;
    else if ((cfg_rd || cfg_wr) && !cfg_smm) used23 <= 1'h1;
  end
  // Counter restarts on each tick so the gap is measured exactly
  always_ff @(posedge clk) begin
    if (sys_rst || refresh_tick) cnt <= 0;
    else cnt <= cnt + 1;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) seen <= 1'h0;
    else if (refresh_tick) seen <= 1'h1;
  end
  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  dma_decode_a: assert property (dma1_sel == (strb && io_addr <= IOD_DMA1_HI))
    else $error("dma1 select wrong");
  pic_decode_a: assert property (pic1_sel == (strb && io_addr inside {[IOD_PIC1_LO:IOD_PIC1_HI]}))
    else $error("pic1 select wrong");
  pit_decode_a: assert property (pit_sel == (strb && io_addr inside {[IOD_PIT_LO:IOD_PIT_HI]}))
    else $error("timer select wrong");
  sysctl_read_a: assert property (io_rd && io_addr == IOD_SYS_CTL |=> io_rdata_valid && io_rdata[7:6] == 2'h0)
    else $error("system control read wrong");
  one_access_a: assert property (strb && io_addr == IOD_CFG_DAT && used23 |-> !cfg_rd && !cfg_wr)
    else $error("second data access honoured");
  index_rearm_a: assert property (io_wr && io_addr == IOD_CFG_IDX ##1 !strb ##1 strb && io_addr == IOD_CFG_DAT |-> (cfg_rd || cfg_wr) && cfg_index == $past(io_wdata, 2))
    else $error("index write did not arm access");
  kbd_clear_a: assert property (io_rd && io_addr == IOD_KBD_CLR && !kbd_irq_set |=> !irq1)
    else $error("keyboard latch not cleared");
  gate_clk_a: assert property (tmr2_clk_en == (tmr2_gate && timer_clk_tick))
    else $error("timer 2 clock gating wrong");
  t2_force_a: assert property (io_rd && io_addr == IOD_SYS_CTL && !tmr2_gate |=> io_rdata[IOD_SC_T2OUT])
    else $error("timer 2 status not forced");
  parity_dis_a: assert property (io_wr && io_addr == IOD_SYS_CTL && io_wdata[IOD_SC_PAR_DIS] |=> parity_check_n [*2])
    else $error("parity flip-flop not preset");
  refresh_gap_a: assert property (seen |-> cnt < REFRESH_CYC && (!refresh_tick || cnt == REFRESH_CYC - 1))
    else $error("refresh period wrong");
endmodule : iod_port_decode_sva

bind iod_port_decode iod_port_decode_sva #(.ADDR_W(ADDR_W), .REFRESH_CYC(REFRESH_CYC)) iod_port_decode_sva_i (
  .clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
  .dma1_sel(dma1_sel), .pic1_sel(pic1_sel), .pit_sel(pit_sel), .cfg_index(cfg_index),
  .cfg_smm(cfg_smm), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .kbd_irq_set(kbd_irq_set),
  .irq1(irq1), .timer_clk_tick(timer_clk_tick), .tmr2_gate(tmr2_gate),
  .tmr2_clk_en(tmr2_clk_en), .parity_check_n(parity_check_n), .refresh_tick(refresh_tick)
);

// *** iod_host.sv ***
`timescale 1ns/1ps
module iod_host (
  input  wire logic        clk,
  output logic      [15:0] io_addr,
  output logic             io_rd,
  output logic             io_wr,
  output logic      [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_rdata_valid
);
  logic       rv;
  logic [7:0] rdat;
  initial begin
    io_addr = 16'h0000;
    io_rd = 1'h0;
    io_wr = 1'h0;
    io_wdata = 8'h00;
  end
  // Callers must write the index before each data access
  // and may pass reserved bits as ones
  task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_rd = ~w;
    io_wr = w;
    @(negedge clk);
    rv = io_rdata_valid;
    rdat = io_rdata;
    io_rd = 1'h0;
    io_wr = 1'h0;
    // Released lines show the inverse so stale values never match
    io_addr = ~a;
    io_wdata = ~d;
  endtask : cyc
endmodule : iod_host

// *** iod_port_decode_tb.sv ***
`timescale 1ns/1ps
module iod_port_decode_tb;
  import iod_pkg::*;
  logic        clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic [15:0] io_addr;
  logic [13:0] snap;
  logic [7:0]  snap_wd;
  logic [7:0]  io_wdata, io_rdata, cfg_index, cfg_wdata, cfg_rdata;
  logic        io_rd, io_wr, io_rdata_valid, dma1_sel, pic1_sel, pit_sel, cfg_smm, cfg_rd;
  logic        cfg_wr, kbd_irq_set, mouse_irq_set, irq1, irq12, timer_clk_tick, tmr2_out;
  logic        tmr2_gate, tmr2_clk_en, speaker, par_err, par_block, iochck_n;
  logic        parity_check_n, chan_check_q, chan_check_nmi_n, refresh_tick;
  int          err_total = 0;
  int          cmp_count = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (io_rd || io_wr) snap <= {dma1_sel, pic1_sel, pit_sel, cfg_rd, cfg_wr, cfg_smm, cfg_index};
  // Write data is only valid while the strobe stands, so keep a copy per write
  always @(posedge clk) if (io_wr) snap_wd <= cfg_wdata;
  iod_port_decode #(.REFRESH_CYC(8)) iod_port_decode_i (
    .clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
    .dma1_sel(dma1_sel), .pic1_sel(pic1_sel), .pit_sel(pit_sel), .cfg_index(cfg_index),
    .cfg_smm(cfg_smm), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .kbd_irq_set(kbd_irq_set), .mouse_irq_set(mouse_irq_set),
    .irq1(irq1), .irq12(irq12), .timer_clk_tick(timer_clk_tick), .tmr2_out(tmr2_out),
    .tmr2_gate(tmr2_gate), .tmr2_clk_en(tmr2_clk_en), .speaker(speaker), .par_err(par_err),
    .par_block(par_block), .iochck_n(iochck_n), .parity_check_n(parity_check_n),
    .chan_check_q(chan_check_q), .chan_check_nmi_n(chan_check_nmi_n),
    .refresh_tick(refresh_tick)
  );
  iod_host iod_host_i (
    .clk(clk), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid)
  );
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    iod_host_i.cyc(a, 1'h1, d);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    iod_host_i.cyc(a, 1'h0, 8'h00);
  endtask : rd
  task automatic pulse_par;
    @(negedge clk);
    par_err = 1'h1;
    @(negedge clk);
    par_err = 1'h0;
  endtask : pulse_par
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_reset;
    rd(IOD_SYS_CTL);
    chk("p61 valid", 16'h0001, iod_host_i.rv);
    chk("p61 reset", 16'h0020, iod_host_i.rdat & 8'hEF);
    chk("speaker", 16'h0001, speaker);
    chk("parity_n", 16'h0001, parity_check_n);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_decode;
    logic [15:0] al [12];
    al = '{16'h00, 16'h0F, 16'h10, 16'h1F, 16'h20, 16'h21, 16'h22, 16'h3F, 16'h40, 16'h43, 16'h44, 16'h4F};
    foreach (al[i]) begin
      rd(al[i]);
      chk("selects", {al[i] <= 16'h0F, al[i] inside {[16'h20:16'h21]}, al[i] inside {[16'h40:16'h43]}}, snap[13:11]);
    end
    $display("t_decode done");
  endtask : t_decode
  task automatic t_cfg;
    cfg_rdata = 8'hC3;
    wr(IOD_CFG_IDX, 8'h5A);
    rd(IOD_CFG_DAT);
    chk("cfg read", 16'h045A, snap[10:0]);
    chk("cfg data", 16'h01C3, {iod_host_i.rv, iod_host_i.rdat});
    rd(IOD_CFG_DAT);
    chk("cfg again", 16'h0000, {snap[10:8], iod_host_i.rv});
    wr(IOD_CFG_DAT, 8'h77);
    chk("cfg wr again", 16'h0000, snap[10:8]);
    rd(IOD_CFG_IDX);
    chk("idx read", 16'h0000, iod_host_i.rv);
    wr(IOD_SMM_IDX, 8'hA5);
    wr(IOD_CFG_IDX, 8'h11);
    rd(IOD_SMM_DAT);
    chk("smm read", 16'h05A5, snap[10:0]);
    rd(IOD_CFG_DAT);
    chk("cfg kept", 16'h0411, snap[10:0]);
    rd(IOD_SMM_DAT);
    chk("smm again", 16'h0000, snap[10:8]);
    wr(IOD_CFG_IDX, 8'h11);
    wr(IOD_CFG_DAT, 8'h66);
    chk("rearm", 16'h0211, snap[10:0]);
    chk("cfg wdata", 16'h0066, snap_wd);
    $display("t_cfg done");
  endtask : t_cfg
  task automatic t_kbd;
    @(negedge clk);
    kbd_irq_set = 1'h1;
    mouse_irq_set = 1'h1;
    @(negedge clk);
    kbd_irq_set = 1'h0;
    mouse_irq_set = 1'h0;
    chk("irq set", 16'h0003, {irq1, irq12});
    rd(IOD_SYS_CTL);
    chk("irq kept", 16'h0003, {irq1, irq12});
    rd(IOD_KBD_CLR);
    chk("irq clear", 16'h0000, {irq1, irq12, iod_host_i.rv});
    $display("t_kbd done");
  endtask : t_kbd
  task automatic t_sysctl;
    logic b;
    tmr2_out = 1'h0;
    timer_clk_tick = 1'h1;
    wr(IOD_SYS_CTL, 8'h03);
    chk("gate", 16'h0003, {tmr2_gate, tmr2_clk_en});
    rd(IOD_SYS_CTL);
    chk("p61 a", 16'h0003, iod_host_i.rdat & 8'hEF);
    chk("spk a", 16'h0001, speaker);
    tmr2_out = 1'h1;
    #1;
    chk("spk b", 16'h0000, speaker);
    rd(IOD_SYS_CTL);
    chk("p61 b", 16'h0023, iod_host_i.rdat & 8'hEF);
    tmr2_out = 1'h0;
    wr(IOD_SYS_CTL, 8'hF2);
    rd(IOD_SYS_CTL);
    chk("p61 c", 16'h0022, iod_host_i.rdat & 8'hEF);
    chk("spk c", 16'h0000, {speaker, tmr2_clk_en});
    wr(IOD_SYS_CTL, 8'h00);
    chk("spk d", 16'h0001, speaker);
    timer_clk_tick = 1'h0;
    b = iod_host_i.rdat[IOD_SC_REFRESH];
    rd(IOD_SYS_CTL);
    b = iod_host_i.rdat[IOD_SC_REFRESH];
    repeat (6) @(negedge clk);
    rd(IOD_SYS_CTL);
    chk("refresh", {15'h0000, ~b}, iod_host_i.rdat[IOD_SC_REFRESH]);
    $display("t_sysctl done");
  endtask : t_sysctl
  task automatic t_checks;
    wr(IOD_SYS_CTL, 8'h00);
    pulse_par();
    chk("par err", 16'h0000, parity_check_n);
    wr(IOD_SYS_CTL, 8'h04);
    chk("par preset", 16'h0001, parity_check_n);
    pulse_par();
    chk("par dis", 16'h0001, parity_check_n);
    wr(IOD_SYS_CTL, 8'h00);
    par_block = 1'h1;
    pulse_par();
    chk("par block", 16'h0001, parity_check_n);
    par_block = 1'h0;
    iochck_n = 1'h0;
    @(negedge clk);
    iochck_n = 1'h1;
    #1;
    chk("chk set", 16'h0002, {chan_check_q, chan_check_nmi_n});
    wr(IOD_SYS_CTL, 8'h08);
    chk("chk dis", 16'h0001, {chan_check_q, chan_check_nmi_n});
    wr(IOD_SYS_CTL, 8'h00);
    chk("chk held", 16'h0001, {chan_check_q, chan_check_nmi_n});
    $display("t_checks done");
  endtask : t_checks
  // -------------------------------------------------------------
  // Sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    cfg_rdata = 8'h00;
    {kbd_irq_set, mouse_irq_set, timer_clk_tick, tmr2_out, par_err, par_block} = 6'h00;
    iochck_n = 1'h1;
    repeat (10) @(negedge clk);
    sys_rst = 1'h0;
    t_reset();
    t_decode();
    t_cfg();
    t_kbd();
    t_sysctl();
    t_checks();
    wrap_up();
  end
  // Whole run needs about 105 cycles; allow ample margin
  initial begin
    #(25 * 3000);
    err_total++;
    $display("Watchdog expired");
    wrap_up();
  end
endmodule : iod_port_decode_tb
